// *** hw/wdc_pkg.sv ***
package wdc_pkg;

  // ----------------------------------------------------------------
  // i/o port decode addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] WDC_CHAN2_LOW_PAGE_ADDR   = 16'h0081;
  localparam logic [15:0] WDC_CHAN3_LOW_PAGE_ADDR   = 16'h0082;
  localparam logic [15:0] WDC_CHAN1_LOW_PAGE_ADDR   = 16'h0083;
  localparam logic [15:0] WDC_CHANNEL_MODE_ADDR     = 16'h00D6;
  localparam logic [15:0] WDC_BYTE_PTR_CLEAR_ADDR   = 16'h00D8;
  localparam logic [15:0] WDC_MASTER_CLEAR_ADDR     = 16'h00DA;
  localparam logic [15:0] WDC_UNMASK_ALL_ADDR       = 16'h00DC;
  localparam logic [15:0] WDC_REQUEST_MASK_ADDR     = 16'h00DE;
  // own choice: mode read counter clear and status read ports
  localparam logic [15:0] WDC_MODE_CNT_CLEAR_ADDR   = 16'h00DD;
  localparam logic [15:0] WDC_STATUS_ADDR           = 16'h00D0;
  // own choice: base address / count register ports (ch 4..7, 2 each)
  localparam logic [15:0] WDC_ADDR_CNT_BASE         = 16'h00C0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int WDC_MODE_XFER_MSB = 7;
  localparam int WDC_MODE_XFER_LSB = 6;
  localparam int WDC_MODE_DEC_BIT  = 5;
  localparam int WDC_MODE_AUTO_BIT = 4;
  localparam int WDC_MODE_TYPE_MSB = 3;
  localparam int WDC_MODE_TYPE_LSB = 2;

  // ----------------------------------------------------------------
  // reset values and selector read-back value
  // ----------------------------------------------------------------
  localparam logic [5:0] WDC_MODE_RST = 6'h00;
  localparam logic [3:0] WDC_MASK_RST = 4'h0;
  localparam logic [7:0] WDC_PAGE_RST = 8'h00;
  localparam logic [1:0] WDC_CHAN_SEL_READ = 2'h3;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WDC_XFER_DEMAND  = 2'b00,
    WDC_XFER_SINGLE  = 2'b01,
    WDC_XFER_BLOCK   = 2'b10,
    WDC_XFER_CASCADE = 2'b11
  } wdc_xfer_t;

  typedef enum logic [1:0] {
    WDC_TYPE_VERIFY = 2'b00,
    WDC_TYPE_WRITE  = 2'b01,
    WDC_TYPE_READ   = 2'b10,
    WDC_TYPE_BAD    = 2'b11
  } wdc_type_t;

endpackage

// *** hw/wdc_fifo.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------------
// small synchronous fifo, valid/ready on both sides
// ------------------------------------------------------------------
module wdc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  // pointer wrap logic only serves power-of-two depths
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("fifo depth must be power of two");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];  // storage
  logic [AW:0]      wp_r;           // write pointer, extra wrap bit
  logic [AW:0]      rp_r;           // read pointer
  logic             push;
  logic             pop;

  // full when pointers differ only in wrap bit
  assign o_in_ready  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign o_out_valid = (wp_r != rp_r);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_r[rp_r[AW-1:0]];

  // pointer update
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  // storage has no reset
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= i_in_data;
    end
  end
endmodule

// *** hw/wdc_regs.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Overview of operation
// R1 - mode bits 7:6 select transfer mode
// R2 - mode bit 5 picks increment or decrement
// R3 - autoinit reloads address and count at tc
// R4 - autoinit channel not masked at tc
// R5 - mode bits 3:2 give transfer type
// R6 - write data 1:0 picks channel mode
// R7 - successive mode reads walk all channels
// R8 - counter clear restarts read walk
// R9 - selector bits read back as 11
// R10 - write 0D8H clears byte pointer
// R11 - write 0DAH performs master clear
// R12 - write 0DCH unmasks all channels
// R13 - 0DEH reads/writes four mask bits
// R14 - mask register clears on processor reset
// R15 - low page registers 081H 082H 083H
// R16 - low page registers reset to zero
// R17 - tc status clears reset, master, read
// R18 - byte pointer toggles per byte access
// ------------------------------------------------------------------
module wdc_regs
  import wdc_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset (i_rst is the processor reset)
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // host i/o cycle, one-cycle strobes
  input  wire logic [15:0] i_io_addr,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [7:0]  i_io_wdata,
  output logic [7:0]       o_io_rdata,
  output logic             o_io_rvalid,
  // per-channel tc pulses from transfer engine, ch 4..7
  input  wire logic [3:0]  i_tc,
  // channel programming state
  output logic [23:0]      o_mode,
  output logic [3:0]       o_mask,
  output logic [23:0]      o_page,
  output logic [63:0]      o_cur_addr,
  output logic [63:0]      o_cur_cnt,
  output logic             o_byte_ptr,
  // mode-write stream: {chan, bits 7:2}
  output logic             o_mw_valid,
  input  wire logic        i_mw_ready,
  output logic [7:0]       o_mw_data
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // stream sizing is fixed at sixteen words
  if (FIFO_DEPTH != 16) begin : g_bad_depth
    $error("fifo depth must be 16");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0][5:0]  mode;     // per-channel mode bits 7:2
    logic [3:0]       mask;     // request mask ch 4..7
    logic [2:0][7:0]  page;     // ch1, ch2, ch3 low page
    logic [3:0][15:0] base_a;   // base address
    logic [3:0][15:0] base_c;   // base count
    logic [3:0][15:0] cur_a;    // current address
    logic [3:0][15:0] cur_c;    // current count
    logic [3:0]       tc_stat;  // sticky tc status
    logic [1:0]       rd_cnt;   // mode read walk counter
    logic             bptr;     // byte pointer flip-flop
    logic [7:0]       rdata;    // read data
    logic             rvalid;   // read answer strobe
  } wdc_state_t;

  wdc_state_t st_r;
  wdc_state_t st_nxt;

  logic       fifo_ready;  // fill-side ready of mode stream fifo
  logic       wr_hit;
  logic [7:0] mw_word;

  // compare the i/o address with one port address, strobe checked by the caller
  function automatic logic hit(input logic [15:0] a, input logic [15:0] p);
    return a == p;
  endfunction

  assign mw_word = {i_io_wdata[1:0], i_io_wdata[7:2]};
  // a mode write is dropped when the stream fifo has no room
  assign wr_hit  = i_io_wr && !(hit(i_io_addr, WDC_CHANNEL_MODE_ADDR) && !fifo_ready);

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] ch;
    logic [2:0] ac;
    logic [3:0] tc_msk;
    // channel index in a[3:2], count select in a[1]
    ch = i_io_addr[3:2];
    ac = 3'(i_io_addr[3:0] >> 1);
    // masks raised by tc in this very cycle
    tc_msk = 4'h0;
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.rdata  = 8'h00;

    // transfer engine tc events
    for (int c = 0; c < 4; c++) begin
      if (i_tc[c]) begin
        st_nxt.tc_stat[c] = 1'b1;
        // R3 reload at tc
        if (st_r.mode[c][WDC_MODE_AUTO_BIT-2]) begin
          st_nxt.cur_a[c] = st_r.base_a[c];
          st_nxt.cur_c[c] = st_r.base_c[c];
        end else begin
          // R4 mask only without autoinit
          st_nxt.mask[c] = 1'b1;
          tc_msk[c]      = 1'b1;
        end
      end
    end

    // host writes
    if (wr_hit) begin
      if (hit(i_io_addr, WDC_CHANNEL_MODE_ADDR)) begin
        // R1 R2 R5 fields stored as written
        // the transfer engine takes them from the mode-write stream
        // R6 data bits 1:0 pick channel
        st_nxt.mode[i_io_wdata[1:0]] = i_io_wdata[7:2];
      end
      if (hit(i_io_addr, WDC_BYTE_PTR_CLEAR_ADDR)) begin
        // R10 clear pointer, data ignored
        st_nxt.bptr = 1'b0;
      end
      if (hit(i_io_addr, WDC_MASTER_CLEAR_ADDR)) begin
        // R11 master clear, data ignored
        st_nxt.bptr    = 1'b0;
        st_nxt.mask    = 4'hF;
        st_nxt.rd_cnt  = 2'h0;
        // R17 master clear drops tc status
        // a tc landing in the same cycle still sets: set wins
        st_nxt.tc_stat = i_tc;
      end
      if (hit(i_io_addr, WDC_UNMASK_ALL_ADDR)) begin
        // R12 unmask every channel
        // a mask raised by tc in this cycle survives
        st_nxt.mask = tc_msk;
      end
      if (hit(i_io_addr, WDC_REQUEST_MASK_ADDR)) begin
        // R13 all four mask bits
        st_nxt.mask = i_io_wdata[3:0];
      end
      if (hit(i_io_addr, WDC_MODE_CNT_CLEAR_ADDR)) begin
        // R8 restart read walk
        st_nxt.rd_cnt = 2'h0;
      end
      // R15 low page registers
      if (hit(i_io_addr, WDC_CHAN1_LOW_PAGE_ADDR)) begin
        st_nxt.page[0] = i_io_wdata;
      end
      if (hit(i_io_addr, WDC_CHAN2_LOW_PAGE_ADDR)) begin
        st_nxt.page[1] = i_io_wdata;
      end
      if (hit(i_io_addr, WDC_CHAN3_LOW_PAGE_ADDR)) begin
        st_nxt.page[2] = i_io_wdata;
      end
      if (i_io_addr[15:4] == WDC_ADDR_CNT_BASE[15:4]) begin
        // R18 byte lane by pointer, then toggle
        if (ac[0] == 1'b0) begin
          st_nxt.base_a[ch][st_r.bptr*8 +: 8] = i_io_wdata;
          st_nxt.cur_a[ch][st_r.bptr*8 +: 8]  = i_io_wdata;
        end else begin
          st_nxt.base_c[ch][st_r.bptr*8 +: 8] = i_io_wdata;
          st_nxt.cur_c[ch][st_r.bptr*8 +: 8]  = i_io_wdata;
        end
        st_nxt.bptr = !st_r.bptr;
      end
    end

    // host reads, answer one cycle later
    if (i_io_rd) begin
      st_nxt.rvalid = 1'b1;
      if (hit(i_io_addr, WDC_CHANNEL_MODE_ADDR)) begin
        // R9 selector reads as 11
        st_nxt.rdata  = {st_r.mode[st_r.rd_cnt], WDC_CHAN_SEL_READ};
        // R7 walk to next channel
        st_nxt.rd_cnt = st_r.rd_cnt + 2'h1;
      end else if (hit(i_io_addr, WDC_REQUEST_MASK_ADDR)) begin
        // R13 reserved upper bits read zero
        st_nxt.rdata = {4'h0, st_r.mask};
      end else if (hit(i_io_addr, WDC_STATUS_ADDR)) begin
        st_nxt.rdata   = {4'h0, st_r.tc_stat};
        // R17 read clears, a same-cycle tc survives
        st_nxt.tc_stat = i_tc;
      end else if (hit(i_io_addr, WDC_CHAN1_LOW_PAGE_ADDR)) begin
        st_nxt.rdata = st_r.page[0];
      end else if (hit(i_io_addr, WDC_CHAN2_LOW_PAGE_ADDR)) begin
        st_nxt.rdata = st_r.page[1];
      end else if (hit(i_io_addr, WDC_CHAN3_LOW_PAGE_ADDR)) begin
        st_nxt.rdata = st_r.page[2];
      end else if (i_io_addr[15:4] == WDC_ADDR_CNT_BASE[15:4]) begin
        st_nxt.rdata = ac[0] ? st_r.cur_c[ch][st_r.bptr*8 +: 8]
                             : st_r.cur_a[ch][st_r.bptr*8 +: 8];
        // R18 read access also toggles
        st_nxt.bptr  = !st_r.bptr;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_r      <= '0;
      st_r.mode <= {4{WDC_MODE_RST}};
      // R14 mask clears on reset
      st_r.mask <= WDC_MASK_RST;
      // R16 pages clear on reset
      st_r.page <= {3{WDC_PAGE_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // mode-write stream buffer
  // ----------------------------------------------------------------
  wdc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_in_valid  (i_io_wr && hit(i_io_addr, WDC_CHANNEL_MODE_ADDR)),
    .o_in_ready  (fifo_ready),
    .i_in_data   (mw_word),
    .o_out_valid (o_mw_valid),
    .i_out_ready (i_mw_ready),
    .o_out_data  (o_mw_data)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_mode      = st_r.mode;
  assign o_mask      = st_r.mask;
  assign o_page      = st_r.page;
  assign o_cur_addr  = st_r.cur_a;
  assign o_cur_cnt   = st_r.cur_c;
  assign o_byte_ptr  = st_r.bptr;
  assign o_io_rdata  = st_r.rdata;
  assign o_io_rvalid = st_r.rvalid;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence mode_wr_s;
    i_io_wr && hit(i_io_addr, WDC_CHANNEL_MODE_ADDR) && fifo_ready;
  endsequence

  mode_store_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R6
    mode_wr_s |=> st_r.mode[$past(i_io_wdata[1:0])] == $past(i_io_wdata[7:2]))
    else $error("mode write not stored");
  mode_sel_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R9
    i_io_rd && hit(i_io_addr, WDC_CHANNEL_MODE_ADDR) |=> o_io_rdata[1:0] == 2'h3)
    else $error("selector bits not 11");
  read_walk_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R7
    i_io_rd && hit(i_io_addr, WDC_CHANNEL_MODE_ADDR) && !i_io_wr
      |=> st_r.rd_cnt == $past(st_r.rd_cnt) + 2'h1)
    else $error("read walk stuck");
  ptr_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R10
    i_io_wr && hit(i_io_addr, WDC_BYTE_PTR_CLEAR_ADDR) && !i_io_rd |=> !o_byte_ptr)
    else $error("byte pointer not cleared");
  unmask_all_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R12
    i_io_wr && hit(i_io_addr, WDC_UNMASK_ALL_ADDR) && i_tc == 4'h0 |=> o_mask == 4'h0)
    else $error("unmask all failed");
  mask_rd_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R13
    i_io_rd && hit(i_io_addr, WDC_REQUEST_MASK_ADDR)
      |=> o_io_rdata == {4'h0, $past(o_mask)} && o_io_rvalid)
    else $error("mask read wrong");
  auto_nomask_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R4
    i_tc[0] && st_r.mode[0][2] && !i_io_wr |=> o_mask[0] == $past(o_mask[0]))
    else $error("autoinit channel masked");
  auto_reload_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R3
    i_tc[0] && st_r.mode[0][2] && !i_io_wr |=> o_cur_addr[15:0] == $past(st_r.base_a[0]))
    else $error("autoinit reload missing");
  master_clr_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R17
    i_io_wr && hit(i_io_addr, WDC_MASTER_CLEAR_ADDR) && i_tc == 4'h0
      |=> st_r.tc_stat == 4'h0 ##0 o_mask == 4'hF)
    else $error("master clear incomplete");

  // R18 every address or count write flips the pointer
  ptr_toggle_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R18
    i_io_wr && !i_io_rd && i_io_addr[15:4] == WDC_ADDR_CNT_BASE[15:4]
      |=> o_byte_ptr != $past(o_byte_ptr))
    else $error("byte pointer did not toggle");
  // R17 status read hands over and clears the sticky bits
  stat_read_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R17
    i_io_rd && hit(i_io_addr, WDC_STATUS_ADDR)
      |=> o_io_rdata == {4'h0, $past(st_r.tc_stat)})
    else $error("status read wrong");
  stat_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R17
    i_io_rd && !i_io_wr && hit(i_io_addr, WDC_STATUS_ADDR) && i_tc == 4'h0
      |=> st_r.tc_stat == 4'h0)
    else $error("status not cleared by read");
  // R17 a tc pulse always leaves its status bit set
  tc_latch_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R17
    i_tc != 4'h0 && !i_io_wr |=> (st_r.tc_stat & $past(i_tc)) == $past(i_tc))
    else $error("tc status not latched");
  // R15 page write lands in its own register
  page_write_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R15
    i_io_wr && hit(i_io_addr, WDC_CHAN2_LOW_PAGE_ADDR) |=> o_page[15:8] == $past(i_io_wdata))
    else $error("page write not stored");
  // R13 all-bits mask write, write beats a same-cycle tc
  mask_write_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R13
    i_io_wr && hit(i_io_addr, WDC_REQUEST_MASK_ADDR) |=> o_mask == $past(i_io_wdata[3:0]))
    else $error("mask write not stored");
  // R8 counter clear restarts the walk
  cnt_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R8
    i_io_wr && !i_io_rd && hit(i_io_addr, WDC_MODE_CNT_CLEAR_ADDR) |=> st_r.rd_cnt == 2'h0)
    else $error("read counter not cleared");
  // R6 a refused mode write leaves every mode untouched
  full_refuse_a: assert property (@(posedge i_mclk) disable iff (i_rst) // R6
    i_io_wr && hit(i_io_addr, WDC_CHANNEL_MODE_ADDR) && !fifo_ready
      |=> st_r.mode == $past(st_r.mode))
    else $error("mode changed while fifo full");

endmodule

// *** test/wdc_engine_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// far side: transfer engine taking mode words and raising tc
// ----------------------------------------------------------------
module wdc_engine_model (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // bench control
  input  wire logic       i_stall,
  input  wire logic [3:0] i_tc_req,
  // mode-word stream
  input  wire logic       i_mw_valid,
  output logic            o_mw_ready,
  input  wire logic [7:0] i_mw_data,
  // observed results
  output logic [3:0]      o_tc,
  output logic [7:0]      o_count,
  output logic [7:0]      o_last
);
  // stalling holds ready low, no word is ever dropped
  assign o_mw_ready = !i_stall;
  // count words taken, keep the last one, launch tc pulses
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_count <= 8'h00;
      o_last  <= 8'h00;
      o_tc    <= 4'h0;
    end else begin
      // one-cycle pulse per request cycle
      o_tc <= i_tc_req;
      if (i_mw_valid && o_mw_ready) begin
        o_count <= o_count + 8'h01;
        o_last  <= i_mw_data;
      end
    end
  end
endmodule

// *** test/wdc_regs_tb.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module wdc_regs_tb;
  import wdc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        i_mclk = 1'b0;
  logic        i_rst = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic        io_wr = 1'b0;
  logic        io_rd = 1'b0;
  logic [7:0]  io_wdata = 8'h00;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [3:0]  tc, tc_req = 4'h0;
  logic [23:0] mode, page;
  logic [3:0]  mask;
  logic [63:0] cur_addr, cur_cnt;
  logic        byte_ptr, mw_valid, mw_ready, stall = 1'b0;
  logic [7:0]  mw_data, rx_count, rx_last, rd_v;
  logic [7:0]  mtab [4] = '{8'h10, 8'h65, 8'hAA, 8'hDB}; // every xfer mode once
  int          failures = 0;
  int          n_tests = 0;
  int          cycles = 0;
  // 10 ns clock
  always #5 i_mclk = ~i_mclk;
  // ----------------------------------------------------------------
  // design and far-side model
  // ----------------------------------------------------------------
  wdc_regs #(.FIFO_DEPTH(16)) dut_u (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_io_addr(io_addr), .i_io_wr(io_wr),
    .i_io_rd(io_rd), .i_io_wdata(io_wdata), .o_io_rdata(rdata), .o_io_rvalid(rvalid),
    .i_tc(tc), .o_mode(mode), .o_mask(mask), .o_page(page), .o_cur_addr(cur_addr),
    .o_cur_cnt(cur_cnt), .o_byte_ptr(byte_ptr), .o_mw_valid(mw_valid),
    .i_mw_ready(mw_ready), .o_mw_data(mw_data));
  wdc_engine_model eng_u (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_stall(stall), .i_tc_req(tc_req),
    .i_mw_valid(mw_valid), .o_mw_ready(mw_ready), .i_mw_data(mw_data), .o_tc(tc),
    .o_count(rx_count), .o_last(rx_last));
  // ----------------------------------------------------------------
  // host i/o tasks: strobe for one edge, inputs moved 1 ns after edges
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk) #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge i_mclk) #1;
    io_wr = 1'b0;
  endtask
  // answer stands right after the taking edge, checked 1 ns later
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_mclk) #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge i_mclk) #1;
    io_rd = 1'b0;
    `CHK(rvalid, 1'b1)
    d = rdata;
  endtask
  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, well above the roughly 150 cycles used
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    `CHK(page, 24'h000000)
    rd(WDC_REQUEST_MASK_ADDR, rd_v);
    `CHK(rd_v, 8'h00)
    `CHK(mode, 24'h000000)
    // each page at its own index
    wr(WDC_CHAN2_LOW_PAGE_ADDR, 8'hA2);
    wr(WDC_CHAN3_LOW_PAGE_ADDR, 8'hB3);
    wr(WDC_CHAN1_LOW_PAGE_ADDR, 8'hC1);
    rd(WDC_CHAN3_LOW_PAGE_ADDR, rd_v);
    `CHK(rd_v, 8'hB3)
    `CHK(page, 24'hB3A2C1)
    // channel picked by data bits 1:0; type 11 never written
    for (int c = 0; c < 4; c++) wr(WDC_CHANNEL_MODE_ADDR, mtab[c]);
    for (int c = 0; c < 4; c++) `CHK(mode[c*6 +: 6], mtab[c][7:2])
    // engine takes the last word one edge after the fifo shows it
    @(posedge i_mclk) #1;
    `CHK(rx_count, 8'h04)
    `CHK(rx_last, 8'hF6)
    wr(WDC_MODE_CNT_CLEAR_ADDR, 8'h5A);
    for (int c = 0; c < 4; c++) begin
      rd(WDC_CHANNEL_MODE_ADDR, rd_v);
      `CHK(rd_v, {mtab[c][7:2], 2'b11})
    end
    // clearing mid-walk restarts at first channel
    rd(WDC_CHANNEL_MODE_ADDR, rd_v);
    wr(WDC_MODE_CNT_CLEAR_ADDR, 8'h00);
    rd(WDC_CHANNEL_MODE_ADDR, rd_v);
    `CHK(rd_v, {mtab[0][7:2], 2'b11})
    // all four mask bits, reserved bits dropped
    wr(WDC_REQUEST_MASK_ADDR, 8'hFA);
    rd(WDC_REQUEST_MASK_ADDR, rd_v);
    `CHK(rd_v, 8'h0A)
    `CHK(mask, 4'hA)
    wr(WDC_UNMASK_ALL_ADDR, 8'hFF);
    `CHK(mask, 4'h0)
    // pointer steps low then high byte of channel 4 base
    wr(WDC_BYTE_PTR_CLEAR_ADDR, 8'hFF);
    wr(WDC_ADDR_CNT_BASE, 8'h34);
    `CHK(byte_ptr, 1'b1)
    wr(WDC_ADDR_CNT_BASE, 8'h12);
    `CHK(byte_ptr, 1'b0)
    wr(WDC_ADDR_CNT_BASE, 8'h77);
    wr(WDC_BYTE_PTR_CLEAR_ADDR, 8'hFF);
    `CHK(byte_ptr, 1'b0)
    // channel 4 count port, then both address bytes read back
    wr(WDC_ADDR_CNT_BASE + 16'h0002, 8'h56);
    wr(WDC_ADDR_CNT_BASE + 16'h0002, 8'h78);
    `CHK(cur_cnt[15:0], 16'h7856)
    rd(WDC_ADDR_CNT_BASE, rd_v);
    `CHK(rd_v, 8'h77)
    rd(WDC_ADDR_CNT_BASE, rd_v);
    `CHK(rd_v, 8'h12)
    `CHK(byte_ptr, 1'b0)
    // tc on ch4 (autoinit) and ch5 (plain)
    @(posedge i_mclk) #1;
    tc_req = 4'h3;
    @(posedge i_mclk) #1;
    tc_req = 4'h0;
    repeat (3) @(posedge i_mclk);
    #1;
    `CHK(mask, 4'h2)
    `CHK(cur_addr[15:0], 16'h1277)
    `CHK(cur_cnt[15:0], 16'h7856)
    rd(WDC_STATUS_ADDR, rd_v);
    `CHK(rd_v[3:0], 4'h3)
    rd(WDC_STATUS_ADDR, rd_v);
    `CHK(rd_v[3:0], 4'h0)
    // master clear masks all, clears pointer and tc status, keeps modes
    wr(WDC_ADDR_CNT_BASE, 8'h00);
    @(posedge i_mclk) #1;
    tc_req = 4'h1;
    @(posedge i_mclk) #1;
    tc_req = 4'h0;
    wr(WDC_MASTER_CLEAR_ADDR, 8'h00);
    rd(WDC_REQUEST_MASK_ADDR, rd_v);
    `CHK(rd_v, 8'h0F)
    `CHK(byte_ptr, 1'b0)
    `CHK(mode[5:0], mtab[0][7:2])
    rd(WDC_STATUS_ADDR, rd_v);
    `CHK(rd_v, 8'h00)
    // fifo: stall, fill 16, seventeenth refused, then drain
    stall = 1'b1;
    for (int i = 0; i < 17; i++) wr(WDC_CHANNEL_MODE_ADDR, {i[4:0], 3'b000});
    `CHK(mw_valid, 1'b1)
    `CHK(mode[5:0], 6'h1E)
    stall = 1'b0;
    repeat (20) @(posedge i_mclk);
    #1;
    `CHK(rx_count, 8'h14)
    `CHK(rx_last, 8'h1E)
    `CHK(mw_valid, 1'b0)
    conclude();
  end
endmodule
